// ==== hdl/tsf_pkg.sv ====
// constants and helpers shared by the task status flag word block
package tsf_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_TASKS    = 2;
  localparam int EVT_PER_TASK = 5;
  localparam int NUM_EVT      = NUM_TASKS * EVT_PER_TASK;
  localparam int ADDR_W       = 12;
  localparam int IDX_W        = ADDR_W - 2;
  localparam int WORD_W       = 16;
  localparam int CODE_W       = 12;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_T1_CODE  = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_T1_STAT  = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_T2_CODE  = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_T2_STAT  = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h010;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h011;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h012;

  // ==========================================================================
  // status word bit positions
  localparam int POS_TASK_ERR    = 0;
  localparam int POS_AUTO        = 2;
  localparam int POS_MANUAL      = 3;
  localparam int POS_RUN         = 4;
  localparam int POS_FINISHED    = 5;
  localparam int POS_OPT_WAIT    = 6;
  localparam int POS_CODE_WAIT   = 7;
  localparam int POS_STROBE      = 8;
  localparam int POS_CYCLE_START = 9;
  localparam int POS_ADDR_DONE   = 12;
  localparam int POS_TEACH_DONE  = 13;
  localparam int POS_TEACH_ERR   = 14;
  localparam int POS_ADDR_OVER   = 15;

  // ==========================================================================
  // control register fields, one bit per task in each
  localparam int POS_CTRL_TEACH    = 0;
  localparam int POS_CTRL_SET_ADDR = 2;
  localparam int POS_CTRL_CODE_RST = 4;

  // ==========================================================================
  // interrupt event slots within a task group
  localparam int EVT_TASK_ERR   = 0;
  localparam int EVT_STROBE     = 1;
  localparam int EVT_TEACH_DONE = 2;
  localparam int EVT_TEACH_ERR  = 3;
  localparam int EVT_ADDR_OVER  = 4;

  // ==========================================================================
  // reset values
  localparam logic [NUM_EVT-1:0]   MASK_RST = 10'h000;
  localparam logic [NUM_TASKS-1:0] CMD_RST  = 2'h0;

  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

  function automatic logic bcd_digit_ok(input logic [3:0] d);
    return d <= BCD_DIGIT_MAX;
  endfunction

endpackage

// ==== hdl/tsf_flags_if.sv ====
// flag bundle from the per-task flag logic to the register bank
`timescale 1ns/1ps
interface tsf_flags_if;
  logic [15:0] task_bits;
  logic [15:0] teach_bits;
  logic [11:0] code;

  modport task_side  (output task_bits, output code);
  modport teach_side (output teach_bits);
  modport reader     (input task_bits, input teach_bits, input code);
endinterface

// ==== hdl/tsf_task_flags.sv ====
// per-task mode, program and auxiliary code flags
`timescale 1ns/1ps
module tsf_task_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        task_error,
  input  wire logic        auto_mode,
  input  wire logic        manual_mode,
  input  wire logic        prog_running,
  input  wire logic        program_end_instruction,
  input  wire logic        opt_input_wait,
  input  wire logic        code_reset_wait,
  input  wire logic        aux_load,
  input  wire logic [11:0] aux_code,
  input  wire logic        code_reset,
  tsf_flags_if.task_side   flags
);

  typedef struct packed {
    logic        err;
    logic        auto_m;
    logic        manual_m;
    logic        run;
    logic        finished;
    logic        opt_wait;
    logic        code_wait;
    logic        strobe;
    logic [11:0] code;
  } tsf_task_state_s;

  tsf_task_state_s st;
  tsf_task_state_s next_st;
  logic            code_ok;
  logic [15:0]     word;

  // ==========================================================================
  // next state
  always_comb begin
    next_st   = st;
    code_ok   = tsf_pkg::bcd_digit_ok(aux_code[11:8]) &
                tsf_pkg::bcd_digit_ok(aux_code[7:4]) &
                tsf_pkg::bcd_digit_ok(aux_code[3:0]);
    next_st.err      = task_error;
    // both modes asserted at once is treated as neither
    next_st.auto_m   = auto_mode & ~manual_mode;
    next_st.manual_m = manual_mode & ~auto_mode;
    next_st.run      = prog_running;
    if (program_end_instruction) begin
      next_st.finished = 1'b1;
    end else if (prog_running) begin
      next_st.finished = 1'b0;
    end
    next_st.opt_wait  = opt_input_wait;
    next_st.code_wait = code_reset_wait;
    // a new code wins over a reset in the same cycle
    if (aux_load && code_ok) begin
      next_st.strobe = 1'b1;
      next_st.code   = aux_code;
    end else if (code_reset) begin
      next_st.strobe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // word assembly, bit 01 stays zero
  always_comb begin
    word                               = 16'h0000;
    word[tsf_pkg::POS_TASK_ERR]        = st.err;
    word[tsf_pkg::POS_AUTO]            = st.auto_m;
    word[tsf_pkg::POS_MANUAL]          = st.manual_m;
    word[tsf_pkg::POS_RUN]             = st.run;
    word[tsf_pkg::POS_FINISHED]        = st.finished;
    word[tsf_pkg::POS_OPT_WAIT]        = st.opt_wait;
    word[tsf_pkg::POS_CODE_WAIT]       = st.code_wait;
    word[tsf_pkg::POS_STROBE]          = st.strobe;
  end

  assign flags.task_bits = word;
  assign flags.code      = st.code;

endmodule

// ==== hdl/tsf_teach_flags.sv ====
// per-task cycle start and teaching handshake flags
`timescale 1ns/1ps
module tsf_teach_flags (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cycle_start,
  input  wire logic       teach_cmd,
  input  wire logic       set_addr_cmd,
  input  wire logic       teach_ok,
  input  wire logic       teach_fail,
  input  wire logic       addr_stored,
  input  wire logic       addr_over,
  tsf_flags_if.teach_side flags
);

  typedef struct packed {
    logic cs;
    logic addr_done;
    logic done;
    logic err;
    logic over;
  } tsf_teach_state_s;

  tsf_teach_state_s st;
  tsf_teach_state_s next_st;
  logic             err_clear;
  logic [15:0]      word;

  // ==========================================================================
  // next state, every set wins over its clear
  always_comb begin
    next_st   = st;
    err_clear = (teach_ok & teach_cmd) | (addr_stored & set_addr_cmd);
    next_st.cs = cycle_start;
    if (addr_stored && set_addr_cmd) begin
      next_st.addr_done = 1'b1;
    end else if (!set_addr_cmd) begin
      next_st.addr_done = 1'b0;
    end
    // done holds while the command stays on, so the host sees it
    if (teach_ok && teach_cmd) begin
      next_st.done = 1'b1;
    end else if (!teach_cmd) begin
      next_st.done = 1'b0;
    end
    if (teach_fail) begin
      next_st.err = 1'b1;
    end else if (err_clear) begin
      next_st.err = 1'b0;
    end
    if (addr_over) begin
      next_st.over = 1'b1;
    end else if (err_clear) begin
      next_st.over = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // word assembly, bits 10 and 11 stay zero
  always_comb begin
    word                           = 16'h0000;
    word[tsf_pkg::POS_CYCLE_START] = st.cs;
    word[tsf_pkg::POS_ADDR_DONE]   = st.addr_done;
    word[tsf_pkg::POS_TEACH_DONE]  = st.done;
    word[tsf_pkg::POS_TEACH_ERR]   = st.err;
    word[tsf_pkg::POS_ADDR_OVER]   = st.over;
  end

  assign flags.teach_bits = word;

endmodule

// ==== hdl/tsf_top.sv ====
// task status flag words and auxiliary code words behind an apb slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module tsf_top (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [tsf_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic                                   irq,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     task_error,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     auto_mode,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     manual_mode,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     prog_running,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     program_end_instruction,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     opt_input_wait,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     code_reset_wait,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     aux_load,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0][11:0] aux_code,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     cycle_start,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     teach_ok,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     teach_fail,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     addr_stored,
  input  wire logic [tsf_pkg::NUM_TASKS-1:0]     addr_over,
  output logic      [tsf_pkg::NUM_TASKS-1:0]     teach_req,
  output logic      [tsf_pkg::NUM_TASKS-1:0]     set_addr_req,
  output logic      [tsf_pkg::NUM_TASKS-1:0]     code_reset_req
);

  typedef struct packed {
    logic [tsf_pkg::NUM_TASKS-1:0] teach_cmd;
    logic [tsf_pkg::NUM_TASKS-1:0] addr_cmd;
    logic [tsf_pkg::NUM_TASKS-1:0] code_rst;
    logic [tsf_pkg::NUM_EVT-1:0]   evt_prev;
    logic [tsf_pkg::NUM_EVT-1:0]   irq_stat;
    logic [tsf_pkg::NUM_EVT-1:0]   irq_mask;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          irq;
  } tsf_top_state_s;

  tsf_top_state_s              st;
  tsf_top_state_s              next_st;
  logic [15:0]                 stat_w [tsf_pkg::NUM_TASKS];
  logic [15:0]                 code_w [tsf_pkg::NUM_TASKS];
  logic [tsf_pkg::NUM_EVT-1:0] evt_now;
  logic [tsf_pkg::NUM_EVT-1:0] evt_rise;
  logic [tsf_pkg::NUM_EVT-1:0] rd_clear;
  logic [tsf_pkg::IDX_W-1:0]   idx;
  logic                        setup;
  logic                        access;
  logic                        hit;
  logic                        wr_ok;
  logic [31:0]                 rd_word;

  // ==========================================================================
  // per-task flag logic
  tsf_flags_if fl [tsf_pkg::NUM_TASKS] ();

  genvar gi;
  generate
    for (gi = 0; gi < tsf_pkg::NUM_TASKS; gi++) begin : g_task
      tsf_task_flags u_task (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .task_error              (task_error[gi]),
        .auto_mode               (auto_mode[gi]),
        .manual_mode             (manual_mode[gi]),
        .prog_running            (prog_running[gi]),
        .program_end_instruction (program_end_instruction[gi]),
        .opt_input_wait          (opt_input_wait[gi]),
        .code_reset_wait         (code_reset_wait[gi]),
        .aux_load                (aux_load[gi]),
        .aux_code                (aux_code[gi]),
        .code_reset              (st.code_rst[gi]),
        .flags                   (fl[gi].task_side)
      );

      tsf_teach_flags u_teach (
        .pclk         (pclk),
        .presetn      (presetn),
        .cycle_start  (cycle_start[gi]),
        .teach_cmd    (st.teach_cmd[gi]),
        .set_addr_cmd (st.addr_cmd[gi]),
        .teach_ok     (teach_ok[gi]),
        .teach_fail   (teach_fail[gi]),
        .addr_stored  (addr_stored[gi]),
        .addr_over    (addr_over[gi]),
        .flags        (fl[gi].teach_side)
      );

      // the two halves never overlap, so or-ing them forms the word
      assign stat_w[gi] = fl[gi].task_bits | fl[gi].teach_bits;
      assign code_w[gi] = {4'h0, fl[gi].code};

      assign evt_now[gi*tsf_pkg::EVT_PER_TASK + tsf_pkg::EVT_TASK_ERR]   = stat_w[gi][tsf_pkg::POS_TASK_ERR];
      assign evt_now[gi*tsf_pkg::EVT_PER_TASK + tsf_pkg::EVT_STROBE]     = stat_w[gi][tsf_pkg::POS_STROBE];
      assign evt_now[gi*tsf_pkg::EVT_PER_TASK + tsf_pkg::EVT_TEACH_DONE] = stat_w[gi][tsf_pkg::POS_TEACH_DONE];
      assign evt_now[gi*tsf_pkg::EVT_PER_TASK + tsf_pkg::EVT_TEACH_ERR]  = stat_w[gi][tsf_pkg::POS_TEACH_ERR];
      assign evt_now[gi*tsf_pkg::EVT_PER_TASK + tsf_pkg::EVT_ADDR_OVER]  = stat_w[gi][tsf_pkg::POS_ADDR_OVER];
    end
  endgenerate

  // ==========================================================================
  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    hit     = 1'b1;
    wr_ok   = 1'b0;
    case (idx)
      tsf_pkg::IDX_T1_CODE: begin
        rd_word = {16'h0000, code_w[0]};
      end
      tsf_pkg::IDX_T1_STAT: begin
        rd_word = {16'h0000, stat_w[0]};
      end
      tsf_pkg::IDX_T2_CODE: begin
        rd_word = {16'h0000, code_w[1]};
      end
      tsf_pkg::IDX_T2_STAT: begin
        rd_word = {16'h0000, stat_w[1]};
      end
      tsf_pkg::IDX_CTRL: begin
        wr_ok = 1'b1;
        rd_word[tsf_pkg::POS_CTRL_TEACH +: tsf_pkg::NUM_TASKS]    = st.teach_cmd;
        rd_word[tsf_pkg::POS_CTRL_SET_ADDR +: tsf_pkg::NUM_TASKS] = st.addr_cmd;
      end
      tsf_pkg::IDX_IRQ_STAT: begin
        rd_word[tsf_pkg::NUM_EVT-1:0] = st.irq_stat;
      end
      tsf_pkg::IDX_IRQ_MASK: begin
        wr_ok = 1'b1;
        rd_word[tsf_pkg::NUM_EVT-1:0] = st.irq_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // bus slave, interrupt and command state
  always_comb begin
    next_st  = st;
    idx      = paddr[tsf_pkg::ADDR_W-1:2];
    setup    = psel & ~penable;
    access   = psel & penable & st.pready;
    evt_rise = evt_now & ~st.evt_prev;
    rd_clear = '0;

    next_st.evt_prev = evt_now;
    next_st.code_rst = '0;
    next_st.pready   = 1'b0;

    // decode in setup so pready and prdata both come from flops
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      next_st.pslverr = ~hit | (paddr[1:0] != 2'b00) | (pwrite & ~wr_ok);
    end

    if (access && pwrite && !st.pslverr) begin
      case (idx)
        tsf_pkg::IDX_CTRL: begin
          next_st.teach_cmd = pwdata[tsf_pkg::POS_CTRL_TEACH +: tsf_pkg::NUM_TASKS];
          next_st.addr_cmd  = pwdata[tsf_pkg::POS_CTRL_SET_ADDR +: tsf_pkg::NUM_TASKS];
          next_st.code_rst  = pwdata[tsf_pkg::POS_CTRL_CODE_RST +: tsf_pkg::NUM_TASKS];
        end
        tsf_pkg::IDX_IRQ_MASK: begin
          next_st.irq_mask = pwdata[tsf_pkg::NUM_EVT-1:0];
        end
        default: begin
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end

    // clear only what the read returned; later events survive
    if (access && !pwrite && !st.pslverr && idx == tsf_pkg::IDX_IRQ_STAT) begin
      rd_clear = st.prdata[tsf_pkg::NUM_EVT-1:0];
    end

    next_st.irq_stat = (st.irq_stat & ~rd_clear) | evt_rise;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.irq_mask  <= tsf_pkg::MASK_RST;
      st.teach_cmd <= tsf_pkg::CMD_RST;
      st.addr_cmd  <= tsf_pkg::CMD_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign irq            = st.irq;
  assign teach_req      = st.teach_cmd;
  assign set_addr_req   = st.addr_cmd;
  assign code_reset_req = st.code_rst;

endmodule

// ==== dv/tsf_monitor.sv ====
// port checker for the task status flag block
`timescale 1ns/1ps
module tsf_monitor (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [tsf_pkg::ADDR_W-1:0]    paddr,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] task_error,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] auto_mode,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] manual_mode,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] cycle_start,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] teach_req,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] set_addr_req,
  input wire logic [tsf_pkg::NUM_TASKS-1:0] code_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // read of the task 2 status word in its access cycle
  sequence s_rd2;
    pready && !pwrite && paddr[11:2] == tsf_pkg::IDX_T2_STAT;
  endsequence
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  property p_ready_single; pready |=> !pready; endproperty
  property p_unused_zero; s_rd2 |-> prdata[1] == 1'b0 && prdata[11:10] == 2'h0 && prdata[31:16] == 16'h0; endproperty
  property p_task_err; task_error[1] [*3] ##0 s_rd2 |-> prdata[0]; endproperty
  property p_auto; (auto_mode[1] && !manual_mode[1]) [*3] ##0 s_rd2 |-> prdata[2]; endproperty
  property p_manual; !manual_mode[1] [*3] ##0 s_rd2 |-> !prdata[3]; endproperty
  property p_cycle; cycle_start[1] [*3] ##0 s_rd2 |-> prdata[9]; endproperty
  // two extra cycles of margin for the clear that follows the command drop
  property p_done_clear; !teach_req[1] [*5] ##0 s_rd2 |-> !prdata[13]; endproperty
  property p_addr_clear; !set_addr_req[1] [*5] ##0 s_rd2 |-> !prdata[12]; endproperty
  property p_code_pulse; code_reset_req[1] |=> !code_reset_req[1]; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
  a_task_err: assert property (p_task_err) else $error("task error bit low");
  a_auto: assert property (p_auto) else $error("auto bit low");
  a_manual: assert property (p_manual) else $error("manual bit high");
  a_cycle: assert property (p_cycle) else $error("cycle start bit low");
  a_done_clear: assert property (p_done_clear) else $error("teach done stuck");
  a_addr_clear: assert property (p_addr_clear) else $error("addr done stuck");
  a_code_pulse: assert property (p_code_pulse) else $error("code reset not a pulse");
endmodule
bind tsf_top tsf_monitor tsf_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .task_error(task_error),
  .auto_mode(auto_mode), .manual_mode(manual_mode), .cycle_start(cycle_start), .teach_req(teach_req),
  .set_addr_req(set_addr_req), .code_reset_req(code_reset_req));

// ==== dv/tsf_host_model.sv ====
// host controller model: apb master plus code and teach handshakes
`timescale 1ns/1ps
module tsf_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
  end
  // ==========================================================================
  // one transfer; ready is sampled at the rising edge, request held until then
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit ok);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata; e = pslverr; ok = (n < 20);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // code word taken only while the strobe shows
  task automatic read_code(output logic [31:0] c, output bit valid);
    logic [31:0] s; logic e; bit ok;
    xfer(1'b0, {tsf_pkg::IDX_T2_STAT, 2'b00}, 32'h0, s, e, ok);
    valid = s[tsf_pkg::POS_STROBE] === 1'b1;
    if (valid) xfer(1'b0, {tsf_pkg::IDX_T2_CODE, 2'b00}, 32'h0, c, e, ok);
  endtask
  // command held until done rises, then withdrawn
  task automatic teach(output bit seen);
    logic [31:0] s; logic e; bit ok;
    xfer(1'b1, {tsf_pkg::IDX_CTRL, 2'b00}, 32'h2, s, e, ok);
    seen = 0;
    for (int i = 0; i < 30 && !seen; i++) begin
      xfer(1'b0, {tsf_pkg::IDX_T2_STAT, 2'b00}, 32'h0, s, e, ok);
      seen = s[tsf_pkg::POS_TEACH_DONE] === 1'b1;
    end
    xfer(1'b1, {tsf_pkg::IDX_CTRL, 2'b00}, 32'h0, s, e, ok);
  endtask
endmodule

// ==== dv/tb_task_status_flag_words.sv ====
// self-checking bench for the task status flag block
`timescale 1ns/1ps
module tb_task_status_flag_words;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, irq, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [13:0] lv = 14'h0;
  logic [11:0] ev = 12'h0;
  logic [1:0][11:0] code = '0;
  logic [1:0]  treq, sreq, creq;
  int          n_mismatch = 0, samples_checked = 0;
  bit          ok, vld;
  localparam logic [11:0] A_STAT = {tsf_pkg::IDX_T2_STAT, 2'b00};
  localparam logic [11:0] A_CTRL = {tsf_pkg::IDX_CTRL, 2'b00};
  always #5 pclk = ~pclk;
  tsf_host_model tsf_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tsf_top tsf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .task_error(lv[1:0]), .auto_mode(lv[3:2]), .manual_mode(lv[5:4]), .prog_running(lv[7:6]),
    .program_end_instruction(ev[9:8]), .opt_input_wait(lv[9:8]), .code_reset_wait(lv[11:10]),
    .aux_load(ev[11:10]), .aux_code(code), .cycle_start(lv[13:12]), .teach_ok(ev[1:0]),
    .teach_fail(ev[3:2]), .addr_stored(ev[5:4]), .addr_over(ev[7:6]), .teach_req(treq),
    .set_addr_req(sreq), .code_reset_req(creq));
  // ==========================================================================
  // helpers
  function automatic logic [31:0] exp_lv(logic [13:0] v, int t);
    logic [31:0] r = 32'h0;
    r[0] = v[t]; r[2] = v[2+t] & ~v[4+t]; r[3] = v[4+t] & ~v[2+t];
    r[4] = v[6+t]; r[6] = v[8+t]; r[7] = v[10+t]; r[9] = v[12+t];
    return r;
  endfunction
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      n_mismatch++;
    end
  endtask
  task automatic rd(logic [11:0] a);
    tsf_host_model_i.xfer(1'b0, a, 32'h0, q, e, ok);
    if (!ok) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    tsf_host_model_i.xfer(1'b1, a, d, q, e, ok);
    if (!ok) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic pulse(int b);
    @(posedge pclk); ev[b] <= 1'b1;
    @(posedge pclk); ev[b] <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================================
  initial begin
    void'($urandom(32'hd709b0b0));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // random level flags on both tasks, including both modes at once
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk); lv <= 14'($urandom);
      repeat (2) @(posedge pclk);
      rd({tsf_pkg::IDX_T1_STAT, 2'b00}); chk("t1 status", exp_lv(lv, 0), q);
      rd(A_STAT); chk("t2 status", exp_lv(lv, 1), q);
    end
    @(posedge pclk); lv <= 14'h0;
    $display("level flag test done");
    pulse(9); rd(A_STAT); chk("finished", 32'h1, 32'(q[5]));
    // strobe, code word and interrupt
    // random level flags left task error events behind, clear them first
    rd({tsf_pkg::IDX_IRQ_STAT, 2'b00});
    wr({tsf_pkg::IDX_IRQ_MASK, 2'b00}, 32'h40);
    @(posedge pclk); code[1] <= {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
    pulse(11);
    tsf_host_model_i.read_code(q, vld);
    chk("strobe", 32'h1, 32'(vld));
    chk("code", {20'h0, code[1]}, q);
    chk("irq on", 32'h1, 32'(irq));
    rd({tsf_pkg::IDX_IRQ_STAT, 2'b00}); chk("irq stat", 32'h40, q);
    // irq drops at the access edge, look one edge later
    @(posedge pclk);
    chk("irq off", 32'h0, 32'(irq));
    wr(A_CTRL, 32'h20); rd(A_STAT); chk("strobe reset", 32'h0, 32'(q[8]));
    @(posedge pclk); code[1] <= 12'h9a9;
    pulse(11); rd(A_STAT); chk("bad code", 32'h0, 32'(q[8]));
    $display("code test done");
    // teaching handshake, error and overrange
    pulse(3); pulse(7); rd(A_STAT); chk("teach err", 32'hc, 32'(q[15:12]));
    fork
      tsf_host_model_i.teach(vld);
      begin repeat (8) @(posedge pclk); pulse(1); end
    join
    chk("teach seen", 32'h1, 32'(vld));
    rd(A_STAT); chk("teach clear", 32'h0, 32'(q[15:12]));
    chk("teach req", 32'h0, 32'(treq));
    pulse(7); wr(A_CTRL, 32'h8); pulse(5);
    chk("set addr req", 32'h2, 32'(sreq));
    rd(A_STAT); chk("addr set", 32'h1, 32'(q[15:12]));
    wr(A_CTRL, 32'h0); rd(A_STAT); chk("addr drop", 32'h0, 32'(q[15:12]));
    $display("teach test done");
    // refused accesses
    wr(A_STAT, 32'hffff); chk("ro write", 32'h1, 32'(e));
    rd(12'hffc); chk("unmapped", 32'h1, 32'(e));
    rd(12'h02e); chk("misaligned", 32'h1, 32'(e));
    $display("access test done");
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
endmodule
